/* design/chip_select_unit.sv */
// Purpose: memory and peripheral select decode with wait and ready control
// Assumes: cycle_start is a one-cycle request from logic on sys_clk
// Notes:   overlapping regions must share wait and ready settings
`default_nettype none
module chip_select_unit (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        cycle_start,
  input  wire logic [19:0] cycle_addr,
  input  wire logic        cycle_io,
  input  wire logic [2:0]  ctrl_sel,
  input  wire logic        ctrl_wr,
  input  wire logic        ctrl_rd,
  input  wire logic [15:0] ctrl_wdata,
  input  wire logic        async_ready_input,
  input  wire logic        sync_ready_input,
  output logic      [15:0] ctrl_rdata,
  output logic             upper_memory_select_n,
  output logic             low_memory_select_n,
  output logic      [3:0]  midrange_memory_selects_n,
  output logic      [3:0]  peripheral_selects_low_n,
  output logic             peripheral_select_5_n,
  output logic             peripheral_select_6_n,
  output logic             cycle_busy,
  output logic             cycle_done
);
  logic [15:0] upper_reg, low_reg, mid_reg, pbase_reg, mps_reg;
  logic        low_en_reg, mid_seen_reg, pbase_seen_reg, mps_seen_reg;
  logic        mid_en, pcs_en, a12_mode;
  logic [1:0]  rdy_a_reg, rdy_s_reg;
  logic        ready;
  logic        up_hit, low_hit, mid_hit;
  logic [3:0]  mcs_vec;
  logic [6:0]  pcs_vec;
  logic [2:0]  mid_n;
  logic [6:0]  mid_mask;
  logic [19:0] mid_shift;
  logic        pblk_hit;
  logic [3:0]  ws_sel;
  logic        rdy_sel;
  logic        up_h_reg, low_h_reg, a1_reg, a2_reg;
  logic [3:0]  mcs_h_reg;
  logic [6:0]  pcs_h_reg;
  logic        start;
  logic        early, late;
  cs_unit_pkg::bus_state_e state_reg, state_next;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_en_reg     <= 1'b0;
      mid_seen_reg   <= 1'b0;
      pbase_seen_reg <= 1'b0;
      mps_seen_reg   <= 1'b0;
    end else if (ctrl_wr || ctrl_rd) begin
      if (ctrl_sel == cs_unit_pkg::SEL_LOW)   low_en_reg     <= 1'b1;
      if (ctrl_sel == cs_unit_pkg::SEL_MID)   mid_seen_reg   <= 1'b1;
      if (ctrl_sel == cs_unit_pkg::SEL_PBASE) pbase_seen_reg <= 1'b1;
      if (ctrl_sel == cs_unit_pkg::SEL_MPS)   mps_seen_reg   <= 1'b1;
    end
  end
  assign mid_en   = mid_seen_reg && mps_seen_reg;
  // peripheral group off until both accessed
  assign pcs_en   = pbase_seen_reg && mps_seen_reg;
  assign a12_mode = mps_reg[cs_unit_pkg::MS_A12_BIT];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upper_reg <= cs_unit_pkg::UPPER_RST;
      low_reg   <= cs_unit_pkg::CTRL_RST;
      mid_reg   <= cs_unit_pkg::CTRL_RST;
      pbase_reg <= cs_unit_pkg::CTRL_RST;
      mps_reg   <= cs_unit_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      if (ctrl_sel == cs_unit_pkg::SEL_UPPER) upper_reg <= ctrl_wdata;
      if (ctrl_sel == cs_unit_pkg::SEL_LOW)   low_reg   <= ctrl_wdata;
      if (ctrl_sel == cs_unit_pkg::SEL_MID)   mid_reg   <= ctrl_wdata;
      if (ctrl_sel == cs_unit_pkg::SEL_PBASE) pbase_reg <= ctrl_wdata;
      if (ctrl_sel == cs_unit_pkg::SEL_MPS)   mps_reg   <= ctrl_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) ctrl_rdata <= 16'h0000;
    else if (ctrl_rd) begin
      unique case (ctrl_sel)
        cs_unit_pkg::SEL_UPPER: ctrl_rdata <= upper_reg;
        cs_unit_pkg::SEL_LOW:   ctrl_rdata <= low_reg;
        cs_unit_pkg::SEL_MID:   ctrl_rdata <= mid_reg;
        cs_unit_pkg::SEL_PBASE: ctrl_rdata <= pbase_reg;
        cs_unit_pkg::SEL_MPS:   ctrl_rdata <= mps_reg;
        default:                ctrl_rdata <= 16'h0000;
      endcase
    end
  end

  // both ready pins synchronised, either one counts
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdy_a_reg <= 2'h0;
      rdy_s_reg <= 2'h0;
    end else begin
      rdy_a_reg <= {rdy_a_reg[0], async_ready_input};
      rdy_s_reg <= {rdy_s_reg[0], sync_ready_input};
    end
  end
  assign ready = rdy_a_reg[1] || rdy_s_reg[1];

  // decode is blind to who started the cycle
  always_comb begin
    up_hit  = !cycle_io && cycle_addr[19:10] >= upper_reg[cs_unit_pkg::BND_LSB +: 10];
    low_hit = low_en_reg && !cycle_io
              && cycle_addr[19:10] <= low_reg[cs_unit_pkg::BND_LSB +: 10];
    // mid block is 8K << size, split four ways; sizes above 512K clamp
    mid_n    = mps_reg[cs_unit_pkg::MS_SIZE_LSB +: 3];
    if (mid_n > cs_unit_pkg::MID_SIZE_MAX) mid_n = cs_unit_pkg::MID_SIZE_MAX;
    mid_mask = 7'h7F << mid_n;
    mid_hit  = mid_en && !cycle_io && ((cycle_addr[19:13] & mid_mask)
               == (mid_reg[cs_unit_pkg::MID_BASE_LSB +: 7] & mid_mask));
    mid_shift = cycle_addr >> (5'h0B + {2'h0, mid_n});
    mcs_vec   = mid_hit ? (4'h1 << mid_shift[1:0]) : 4'h0;
    // 256-byte slots above the peripheral base
    if (mps_reg[cs_unit_pkg::MS_IO_BIT])
      pblk_hit = cycle_io && cycle_addr[19:16] == 4'h0
                 && cycle_addr[15:11] == pbase_reg[cs_unit_pkg::PB_BASE_LSB +: 5];
    else
      pblk_hit = !cycle_io && cycle_addr[19:11] == pbase_reg[cs_unit_pkg::PB_BASE_LSB +: 9];
    pcs_vec = (pcs_en && pblk_hit) ? 7'(8'h01 << cycle_addr[10:8]) : 7'h00;
    ws_sel  = 4'h0;
    rdy_sel = 1'b0;
    if (up_hit) begin
      ws_sel  = {2'h0, upper_reg[cs_unit_pkg::WS_LSB +: 2]};
      rdy_sel = upper_reg[cs_unit_pkg::RDY_BIT];
    end else if (low_hit) begin
      ws_sel  = {2'h0, low_reg[cs_unit_pkg::WS_LSB +: 2]};
      rdy_sel = low_reg[cs_unit_pkg::RDY_BIT];
    end else if (mid_hit) begin
      ws_sel  = {2'h0, mid_reg[cs_unit_pkg::WS_LSB +: 2]};
      rdy_sel = mid_reg[cs_unit_pkg::RDY_BIT];
    end else if (|pcs_vec[4:0]) begin
      ws_sel  = cs_unit_pkg::wide_wait(pbase_reg[cs_unit_pkg::WS_LSB +: 3]);
      rdy_sel = pbase_reg[cs_unit_pkg::PB_RDY_BIT];
    end else if (|pcs_vec[6:5] && !a12_mode) begin
      // address-bit mode switches off wait logic of selects 5 and 6
      ws_sel  = {2'h0, mps_reg[cs_unit_pkg::WS_LSB +: 2]};
      rdy_sel = mps_reg[cs_unit_pkg::RDY_BIT];
    end
  end

  assign start = cycle_start && state_reg == cs_unit_pkg::ST_IDLE;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      up_h_reg  <= 1'b0;
      low_h_reg <= 1'b0;
      mcs_h_reg <= 4'h0;
      pcs_h_reg <= 7'h00;
      a1_reg    <= 1'b0;
      a2_reg    <= 1'b0;
    end else if (start) begin
      up_h_reg  <= up_hit;
      low_h_reg <= low_hit;
      mcs_h_reg <= mcs_vec;
      pcs_h_reg <= pcs_vec;
      // address bits held for the whole cycle
      a1_reg    <= cycle_addr[1];
      a2_reg    <= cycle_addr[2];
    end
  end

  wait_sequencer u_seq (
    .sys_clk        (sys_clk),
    .srst           (srst),
    .start          (start),
    .wait_count     (ws_sel),
    .ready_required (rdy_sel),
    .ready          (ready),
    .state_reg      (state_reg),
    .state_next     (state_next)
  );

  assign early = state_next != cs_unit_pkg::ST_IDLE;
  assign late  = early && state_next != cs_unit_pkg::ST_T1;

  // selects only inside a live cycle and hit; in address-bit mode pins 5 and 6 carry the latched address bits instead
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upper_memory_select_n     <= 1'b1;
      low_memory_select_n       <= 1'b1;
      midrange_memory_selects_n <= 4'hF;
      peripheral_selects_low_n  <= 4'hF;
      peripheral_select_5_n     <= 1'b1;
      peripheral_select_6_n     <= 1'b1;
      cycle_busy                <= 1'b0;
      cycle_done                <= 1'b0;
    end else begin
      upper_memory_select_n     <= !(early && (start ? up_hit : up_h_reg));
      low_memory_select_n       <= !(early && (start ? low_hit : low_h_reg));
      midrange_memory_selects_n <= ~({4{late}} & mcs_h_reg);
      // six peripheral pins, slot 4 stays internal
      peripheral_selects_low_n  <= ~({4{late}} & pcs_h_reg[3:0]);
      peripheral_select_5_n     <= a12_mode ? (start ? cycle_addr[1] : a1_reg)
                                            : !(late && pcs_h_reg[5]);
      peripheral_select_6_n     <= a12_mode ? (start ? cycle_addr[2] : a2_reg)
                                            : !(late && pcs_h_reg[6]);
      cycle_busy                <= early;
      cycle_done                <= state_next == cs_unit_pkg::ST_T4;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  upper_reset_live_a : assert property (
    $past(srst) |-> upper_reg == cs_unit_pkg::UPPER_RST && !low_en_reg)
    else $error("upper region not at reset default");
  pcs_quiet_a : assert property (
    !pcs_en |-> peripheral_selects_low_n == 4'hF)
    else $error("peripheral select before programming");
  access_enables_a : assert property (
    (ctrl_rd || ctrl_wr) && ctrl_sel == cs_unit_pkg::SEL_LOW |=> low_en_reg)
    else $error("access did not enable low group");
  upper_early_a : assert property (
    start && up_hit |=> !upper_memory_select_n ##1 !upper_memory_select_n)
    else $error("upper select late");
  mid_late_a : assert property (
    state_reg == cs_unit_pkg::ST_T1 |-> midrange_memory_selects_n == 4'hF)
    else $error("mid select in T1");
  basic_length_a : assert property (
    start && ws_sel == 4'h0 && !rdy_sel |-> ##4 cycle_done ##1 !cycle_busy)
    else $error("basic cycle not four clocks");
  idle_quiet_a : assert property (
    !cycle_busy |-> upper_memory_select_n && low_memory_select_n
      && midrange_memory_selects_n == 4'hF)
    else $error("select outside a cycle");
  addr_hold_a : assert property (
    a12_mode && $stable(a12_mode) && cycle_busy && $past(cycle_busy)
      |-> $stable(peripheral_select_5_n) && $stable(peripheral_select_6_n))
    else $error("latched address moved in cycle");

  zero_wait_c  : cover property (start ##4 cycle_done);
  ready_wait_c : cover property (state_reg == cs_unit_pkg::ST_TRDY
    ##1 state_reg == cs_unit_pkg::ST_TX ##1 cycle_done);
  pcs_hit_c    : cover property (!peripheral_selects_low_n[0]);
endmodule : chip_select_unit
`default_nettype wire

/* shared/cs_unit_pkg.sv */
// Purpose: shared constants for the chip-select and wait-state unit
// Assumes: 20-bit memory addresses, 16-bit i/o addresses, 16-bit control words
// Notes:   control word layouts are local to this unit
`default_nettype none
package cs_unit_pkg;
  // control register index on ctrl_sel
  localparam logic [2:0] SEL_UPPER = 3'h0;
  localparam logic [2:0] SEL_LOW   = 3'h1;
  localparam logic [2:0] SEL_MID   = 3'h2;
  localparam logic [2:0] SEL_PBASE = 3'h3;
  localparam logic [2:0] SEL_MPS   = 3'h4;
  // common fields
  localparam int WS_LSB  = 0;
  localparam int RDY_BIT = 2;
  // upper: lower boundary addr[19:10]; low: upper boundary addr[19:10]
  localparam int BND_LSB = 6;
  // mid: block base addr[19:13]
  localparam int MID_BASE_LSB = 9;
  // peripheral base: addr[19:11]; three-bit wait code for slots 0..4
  localparam int PB_BASE_LSB  = 7;
  localparam int PB_RDY_BIT   = 3;
  // mid/peripheral size control
  localparam int MS_SIZE_LSB  = 12;
  localparam int MS_IO_BIT    = 7;
  localparam int MS_A12_BIT   = 6;
  localparam logic [2:0] MID_SIZE_MAX = 3'h6;
  // upper region out of reset: F0000h..FFFFFh, ready required, three waits
  localparam logic [15:0] UPPER_RST = 16'hF007;
  localparam logic [15:0] CTRL_RST  = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1   = 3'b001,
    ST_T2   = 3'b010,
    ST_T3   = 3'b011,
    ST_TW   = 3'b100,
    ST_TRDY = 3'b101,
    ST_TX   = 3'b110,
    ST_T4   = 3'b111
  } bus_state_e;

  // three-bit wait code: 0..3, then 5, 7, 9, 15
  function automatic logic [3:0] wide_wait(input logic [2:0] code);
    logic [3:0] w;
    w = 4'h0;
    case (code)
      3'h4:    w = 4'h5;
      3'h5:    w = 4'h7;
      3'h6:    w = 4'h9;
      3'h7:    w = 4'hF;
      default: w = {1'b0, code};
    endcase
    return w;
  endfunction : wide_wait
endpackage : cs_unit_pkg
`default_nettype wire

/* design/wait_sequencer.sv */
// Purpose: bus cycle phase sequencer with programmed waits and ready
// Assumes: start only while idle; ready already synchronised
// Notes:   wait count and ready mode are latched at start
`default_nettype none
module wait_sequencer (
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    start,
  input  wire logic [3:0]              wait_count,
  input  wire logic                    ready_required,
  input  wire logic                    ready,
  output var  cs_unit_pkg::bus_state_e state_reg,
  output var  cs_unit_pkg::bus_state_e state_next
);
  logic [3:0] ws_reg;
  logic [3:0] cnt_reg;
  logic       req_reg;
  logic       miss_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cs_unit_pkg::ST_IDLE: if (start) state_next = cs_unit_pkg::ST_T1;
      cs_unit_pkg::ST_T1:   state_next = cs_unit_pkg::ST_T2;
      cs_unit_pkg::ST_T2:   state_next = cs_unit_pkg::ST_T3;
      cs_unit_pkg::ST_T3: begin
        if (ws_reg != 4'h0) state_next = cs_unit_pkg::ST_TW;
        else if (req_reg && !ready) state_next = cs_unit_pkg::ST_TRDY;
        else state_next = cs_unit_pkg::ST_T4;
      end
      cs_unit_pkg::ST_TW: begin
        if (cnt_reg == 4'h1) begin
          if (req_reg && (miss_reg || (ws_reg == 4'h1 && !ready)))
            state_next = cs_unit_pkg::ST_TRDY;
          else
            state_next = cs_unit_pkg::ST_T4;
        end
      end
      cs_unit_pkg::ST_TRDY: if (ready) state_next = cs_unit_pkg::ST_TX;
      cs_unit_pkg::ST_TX:   state_next = cs_unit_pkg::ST_T4;
      cs_unit_pkg::ST_T4:   state_next = cs_unit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) state_reg <= cs_unit_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ws_reg  <= 4'h0;
      req_reg <= 1'b0;
    end else if (start && state_reg == cs_unit_pkg::ST_IDLE) begin
      ws_reg  <= wait_count;
      req_reg <= ready_required;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg  <= 4'h0;
      miss_reg <= 1'b0;
    end else if (state_reg == cs_unit_pkg::ST_T3) begin
      cnt_reg  <= ws_reg;
      miss_reg <= 1'b0;
    end else if (state_reg == cs_unit_pkg::ST_TW) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == ws_reg && !ready) miss_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  wait_hold_a : assert property (
    state_reg == cs_unit_pkg::ST_TW && cnt_reg > 4'h1 |=> state_reg == cs_unit_pkg::ST_TW)
    else $error("programmed wait cut short");
  extra_wait_a : assert property (
    state_reg == cs_unit_pkg::ST_TRDY && ready
      |=> state_reg == cs_unit_pkg::ST_TX ##1 state_reg == cs_unit_pkg::ST_T4)
    else $error("no single extra wait after ready");
  ready_ignored_a : assert property (
    state_reg == cs_unit_pkg::ST_TW && cnt_reg == 4'h1 && !req_reg
      |=> state_reg == cs_unit_pkg::ST_T4)
    else $error("ready honoured while ignored");
  ready_first_wait_a : assert property (
    state_reg == cs_unit_pkg::ST_TW && cnt_reg == ws_reg && req_reg && ready
      ##1 state_reg == cs_unit_pkg::ST_TW [*1] |-> !miss_reg)
    else $error("ready in first wait not taken");
endmodule : wait_sequencer
`default_nettype wire

/* dv/ext_ready_model.sv */
// Purpose: external memory and peripheral side, answering on a ready pin
// Assumes: a device is selected while any select line is low
// Notes:   ready lines idle high through pull-ups; unused pin held low
`default_nettype none
module ext_ready_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] sel_n,
  input  wire logic [7:0]  hold_cycles,
  input  wire logic        force_low,
  input  wire logic        use_sync,
  output logic             async_ready,
  output logic             sync_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] busy_cnt_reg;
  logic       rdy;

  // slow device: ready low for hold_cycles after select
  always_ff @(posedge sys_clk) begin
    if (&sel_n) begin
      busy_cnt_reg <= 8'h00;
    end else if (busy_cnt_reg != 8'hFF) begin
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    end
  end

  // pull-up level when nobody is selected
  assign rdy         = force_low ? 1'b0 : ((&sel_n) ? 1'b1 : (busy_cnt_reg >= hold_cycles));
  assign async_ready = use_sync ? 1'b0 : rdy;
  assign sync_ready  = use_sync ? rdy : 1'b0;
endmodule : ext_ready_model
`default_nettype wire

/* dv/chip_select_unit_tb_top.sv */
// Purpose: directed checks of select decode, waits and ready handling
// Assumes: selects packed as {psel6, psel5, psel3..0, mid3..0, low, upper}
// Notes:   cycle count n is 1 in T1, so T4 lands at n = 4 + waits
`default_nettype none
module chip_select_unit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam time DLY = 10ns;
  logic        sys_clk, srst, cycle_start, cycle_io, ctrl_wr, ctrl_rd;
  logic [19:0] cycle_addr;
  logic [2:0]  ctrl_sel;
  logic [15:0] ctrl_wdata, ctrl_rdata;
  logic        async_ready_input, sync_ready_input;
  logic        upper_n, low_n, psel5_n, psel6_n, cycle_busy, cycle_done;
  logic [3:0]  mid_n, psel_n;
  logic [7:0]  hold_cycles;
  logic        force_low, use_sync, addr_mode;
  logic [1:0]  pins_seen;
  wire  [11:0] sel_n = {psel6_n, psel5_n, psel_n, mid_n, low_n, upper_n};
  int          fails, checks, last_n;
  int          wide_tab[8] = '{0, 1, 2, 3, 5, 7, 9, 15};

  chip_select_unit chip_select_unit_inst (
    .sys_clk(sys_clk), .srst(srst), .cycle_start(cycle_start), .cycle_addr(cycle_addr),
    .cycle_io(cycle_io), .ctrl_sel(ctrl_sel), .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd),
    .ctrl_wdata(ctrl_wdata), .async_ready_input(async_ready_input),
    .sync_ready_input(sync_ready_input), .ctrl_rdata(ctrl_rdata),
    .upper_memory_select_n(upper_n), .low_memory_select_n(low_n),
    .midrange_memory_selects_n(mid_n), .peripheral_selects_low_n(psel_n),
    .peripheral_select_5_n(psel5_n), .peripheral_select_6_n(psel6_n),
    .cycle_busy(cycle_busy), .cycle_done(cycle_done));

  ext_ready_model ext_ready_model_inst (
    .sys_clk(sys_clk), .sel_n(sel_n), .hold_cycles(hold_cycles), .force_low(force_low),
    .use_sync(use_sync), .async_ready(async_ready_input), .sync_ready(sync_ready_input));

  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic ctrl_write(input logic [2:0] sel, input logic [15:0] data);
    ctrl_sel = sel;
    ctrl_wdata = data;
    ctrl_wr = 1'b1;
    @(posedge sys_clk);
    #DLY;
    ctrl_wr = 1'b0;
  endtask : ctrl_write

  task automatic ctrl_read(input logic [2:0] sel, input logic [15:0] exp);
    ctrl_sel = sel;
    ctrl_rd = 1'b1;
    @(posedge sys_clk);
    #DLY;
    ctrl_rd = 1'b0;
    // idle edge so a following read never re-raises the strobe at once
    @(posedge sys_clk);
    #DLY;
    check("ctrl_rdata", ctrl_rdata, exp);
  endtask : ctrl_read

  // exp_n below zero leaves the length to the caller via last_n
  task automatic run_cycle(input logic [19:0] addr, input logic io, input int exp_n,
                           input logic [11:0] exp_mask, input int exp_first);
    logic [11:0] seen_mask;
    logic [11:0] care;
    int          n;
    int          first;
    seen_mask = 12'h000;
    first = 0;
    care = addr_mode ? 12'h3FF : 12'hFFF;
    cycle_addr = addr;
    cycle_io = io;
    cycle_start = 1'b1;
    @(posedge sys_clk);
    #DLY;
    cycle_start = 1'b0;
    n = 1;
    while (1) begin
      if (first == 0 && (~sel_n & care) != 12'h000) first = n;
      seen_mask |= ~sel_n & care;
      if (cycle_done === 1'b1 || n >= 40) break;
      @(posedge sys_clk);
      #DLY;
      n++;
    end
    last_n = n;
    pins_seen = sel_n[11:10];
    check("busy_in_t4", cycle_busy, 1'b1);
    if (exp_n >= 0) check("cycle_len", 20'(n), 20'(exp_n));
    check("select_mask", seen_mask, exp_mask);
    check("first_low", 20'(first), 20'(exp_first));
    @(posedge sys_clk);
    #DLY;
    check("released", {cycle_busy, sel_n & care}, {1'b0, care});
  endtask : run_cycle

  initial begin
    #2_000_000;
    fails++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    {cycle_start, cycle_io, ctrl_wr, ctrl_rd, force_low, use_sync, addr_mode} = 7'h00;
    {cycle_addr, ctrl_sel, ctrl_wdata, hold_cycles} = '0;
    fails = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    #DLY;
    srst = 1'b0;
    check("reset_out", {cycle_busy, cycle_done, sel_n}, {2'b00, 12'hFFF});
    ctrl_read(cs_unit_pkg::SEL_UPPER, cs_unit_pkg::UPPER_RST);
    run_cycle(20'hF0000, 1'b0, 7, 12'h001, 1);
    run_cycle(20'hFFFFF, 1'b0, 7, 12'h001, 1);
    run_cycle(20'hEFFFF, 1'b0, 4, 12'h000, 0);
    run_cycle(20'h00000, 1'b0, 4, 12'h000, 0);
    run_cycle(20'h01000, 1'b1, 4, 12'h000, 0);
    ctrl_read(3'h5, 16'h0000);
    // a read alone opens the low group
    ctrl_read(cs_unit_pkg::SEL_LOW, 16'h0000);
    run_cycle(20'h003FF, 1'b0, 4, 12'h002, 1);
    run_cycle(20'h00400, 1'b0, 4, 12'h000, 0);
    // regions kept apart so wait settings never conflict
    ctrl_write(cs_unit_pkg::SEL_LOW, 16'h0046);
    run_cycle(20'h007FF, 1'b0, 6, 12'h002, 1);
    use_sync = 1'b1;
    run_cycle(20'h007FF, 1'b0, 6, 12'h002, 1);
    hold_cycles = 8'h06;
    run_cycle(20'h00000, 1'b0, -1, 12'h002, 1);
    // device ready after 6 clocks, seen 2 later, then one extra wait
    check("late_ready_len", 20'(last_n), 20'h0000B);
    // no programmed waits: ready judged in T3, here on the async pin
    use_sync = 1'b0;
    ctrl_write(cs_unit_pkg::SEL_LOW, 16'h0044);
    run_cycle(20'h00000, 1'b0, 11, 12'h002, 1);
    hold_cycles = 8'h00;
    force_low = 1'b1;
    for (int w = 0; w < 4; w++) begin
      ctrl_write(cs_unit_pkg::SEL_LOW, 16'h0040 | 16'(w));
      run_cycle(20'h00000, 1'b0, 4 + w, 12'h002, 1);
    end
    force_low = 1'b0;
    ctrl_write(cs_unit_pkg::SEL_MID, 16'h2001);
    run_cycle(20'h20000, 1'b0, 4, 12'h000, 0);
    ctrl_write(cs_unit_pkg::SEL_MPS, 16'h0081);
    for (int i = 0; i < 4; i++) begin
      run_cycle(20'h20000 + 20'(i * 'h800), 1'b0, 5, 12'h004 << i, 2);
    end
    run_cycle(20'h01000, 1'b1, 4, 12'h000, 0);
    for (int c = 0; c < 8; c++) begin
      ctrl_write(cs_unit_pkg::SEL_PBASE, 16'h0100 | 16'(c));
      run_cycle(20'h01000, 1'b1, 4 + wide_tab[c], 12'h040, 2);
    end
    ctrl_write(cs_unit_pkg::SEL_PBASE, 16'h0100);
    // slot 4 has no pin; 5 and 6 take the mps wait field
    for (int s = 0; s < 7; s++) begin
      run_cycle(20'h01000 + 20'(s * 'h100), 1'b1, (s > 4) ? 5 : 4,
                (s < 4) ? (12'h040 << s) : ((s == 4) ? 12'h000 : (12'h400 << (s - 5))),
                (s == 4) ? 0 : 2);
    end
    run_cycle(20'h010FF, 1'b1, 4, 12'h040, 2);
    run_cycle(20'h01000, 1'b0, 4, 12'h000, 0);
    ctrl_write(cs_unit_pkg::SEL_MPS, 16'h00C1);
    addr_mode = 1'b1;
    run_cycle(20'h00002, 1'b0, 7, 12'h002, 1);
    check("addr_pins", pins_seen, 2'b01);
    run_cycle(20'h00004, 1'b0, 7, 12'h002, 1);
    check("addr_pins", pins_seen, 2'b10);
    // peripherals back in memory space, address mode off
    ctrl_write(cs_unit_pkg::SEL_MPS, 16'h0001);
    addr_mode = 1'b0;
    run_cycle(20'h01600, 1'b0, 5, 12'h800, 2);
    run_cycle(20'h01600, 1'b1, 4, 12'h000, 0);
    complete_run();
  end
endmodule : chip_select_unit_tb_top
`default_nettype wire
